// *** logic/mmr_minmax_bank.sv ***
// Measurement register bank holding real-time values and their tracked extremes.
module mmr_minmax_bank #(
	parameter int PARAMS = mmr_pkg::PARAM_COUNT,
	parameter logic [299:0] SIGNED_MASK = '0,
	parameter logic [299:0] NO_MIN_MASK = mmr_pkg::NO_EXTREME_MASK,
	parameter logic [299:0] NO_MAX_MASK = mmr_pkg::NO_EXTREME_MASK
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic updateValid,
	input wire logic [mmr_pkg::INDEX_WIDTH-1:0] updateIndex,
	input wire logic [mmr_pkg::DATA_WIDTH-1:0] updateValue,
	input wire logic commandValid,
	input wire logic [mmr_pkg::DATA_WIDTH-1:0] commandCode,
	input wire logic readValid,
	input wire logic [mmr_pkg::ADDR_WIDTH-1:0] readRegister,
	output logic [mmr_pkg::DATA_WIDTH-1:0] readData,
	output logic readDone,
	output logic readError
);
	localparam int W = mmr_pkg::DATA_WIDTH;

	if (PARAMS < 1 || PARAMS > mmr_pkg::PARAM_COUNT) begin : gCheck
		$error("PARAMS must lie between 1 and 300.");
	end

	// The index field must reach every entry, and the three windows must not
	// overlap, or one register number would answer for two slots.
	if (PARAMS > (1 << mmr_pkg::INDEX_WIDTH)) begin : gIndexCheck
		$error("PARAMS does not fit the index width.");
	end
	if (32'(mmr_pkg::RT_BASE) + PARAMS > 32'(mmr_pkg::MIN_BASE)) begin : gLiveCheck
		$error("Live window runs into the minimum window.");
	end
	if (32'(mmr_pkg::MIN_BASE) + PARAMS > 32'(mmr_pkg::MAX_BASE)) begin : gMinCheck
		$error("Minimum window runs into the maximum window.");
	end

	logic [W-1:0] rtMem [PARAMS];
	logic [W-1:0] minMem [PARAMS];
	logic [W-1:0] maxMem [PARAMS];
	logic [PARAMS-1:0] rtValid_q;
	wire logic [PARAMS-1:0] rtValid_d;
	logic [PARAMS-1:0] extValid_q;
	wire logic [PARAMS-1:0] extValid_d;
	logic [W-1:0] readData_q;
	logic readDone_q;
	logic readError_q;

	wire logic clearCmd;
	wire logic updateHit;
	wire logic updSigned;
	wire logic updNewMin;
	wire logic updNewMax;
	wire logic writeMin;
	wire logic writeMax;
	wire logic [W-1:0] storedMin;
	wire logic [W-1:0] storedMax;
	wire logic [15:0] rtOff;
	wire logic [15:0] minOff;
	wire logic [15:0] maxOff;
	wire logic inRt;
	wire logic inMin;
	wire logic inMax;
	wire logic [mmr_pkg::INDEX_WIDTH-1:0] rtIdx;
	wire logic [mmr_pkg::INDEX_WIDTH-1:0] minIdx;
	wire logic [mmr_pkg::INDEX_WIDTH-1:0] maxIdx;
	wire logic [W-1:0] rtWord;
	wire logic [W-1:0] minWord;
	wire logic [W-1:0] maxWord;
	wire logic [W-1:0] readMux;
	wire logic rtStore;
	wire logic minStore;
	wire logic maxStore;
	wire logic readTake;
	wire logic readMapped;
	wire logic rtBlank;
	wire logic minBlank;
	wire logic maxBlank;

	// Any other command code is dropped without an answer, and refreshes for
	// indices past the end of the bank are ignored.
	assign clearCmd = commandValid && (commandCode == mmr_pkg::CLEAR_EXTREMES_CODE);
	assign updateHit = updateValid && (32'(updateIndex) < PARAMS);
	assign storedMin = minMem[updateIndex];
	assign storedMax = maxMem[updateIndex];
	assign updSigned = SIGNED_MASK[updateIndex];

	// Two comparators work side by side against the stored minimum and maximum;
	// sharing one would need a second cycle per refresh, and refreshes may come
	// back to back.

	mmr_extreme_compare #(
		.WIDTH(W)
	) uCompareMin (
		.sample(updateValue),
		.stored(storedMin),
		.signedMode(updSigned),
		.newMin(updNewMin),
		.newMax()
	);

	mmr_extreme_compare #(
		.WIDTH(W)
	) uCompareMax (
		.sample(updateValue),
		.stored(storedMax),
		.signedMode(updSigned),
		.newMin(),
		.newMax(updNewMax)
	);

	// A first sample after a clear seeds both extremes; a clear in the same
	// cycle as a refresh still keeps that refresh as the new first sample.
	assign writeMin = updateHit && (!extValid_q[updateIndex] || clearCmd || updNewMin);
	assign writeMax = updateHit && (!extValid_q[updateIndex] || clearCmd || updNewMax);

	// Per-entry valid bits: a live slot stays valid once refreshed, while an
	// extreme valid bit drops on a clear unless a refresh lands in that cycle,
	// in which case the refresh wins and seeds the new extremes.
	for (genvar i = 0; i < PARAMS; i++) begin : gEntry
		wire logic hit;
		assign hit = updateHit && (32'(updateIndex) == i);
		assign rtValid_d[i] = rtValid_q[i] | hit;
		assign extValid_d[i] = hit | (extValid_q[i] & ~clearCmd);
	end

	// Values are stored raw, so extremes keep the scale and encoding of the source.
	// The enables fold in the clock enable, so a frozen block never takes a refresh.
	assign rtStore = clockEnable && updateHit;
	assign minStore = clockEnable && writeMin;
	assign maxStore = clockEnable && writeMax;

	always_ff @(posedge clock) begin
		if (rtStore) begin
			rtMem[updateIndex] <= updateValue;
		end
	end

	always_ff @(posedge clock) begin
		if (minStore) begin
			minMem[updateIndex] <= updateValue;
		end
	end

	always_ff @(posedge clock) begin
		if (maxStore) begin
			maxMem[updateIndex] <= updateValue;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rtValid_q <= '0;
		end else if (clockEnable) begin
			rtValid_q <= rtValid_d;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			extValid_q <= '0;
		end else if (clockEnable) begin
			extValid_q <= extValid_d;
		end
	end

	// Register numbers 1000..1299 hold the live values, including the
	// distortion and thermal image words. The minimum window sits 300 numbers
	// higher and the maximum window 600 numbers higher, in the same order.
	// Each offset wraps below its base, which is why every window also
	// compares the register number against that base.
	assign rtOff = readRegister - mmr_pkg::RT_BASE;
	assign minOff = readRegister - mmr_pkg::MIN_BASE;
	assign maxOff = readRegister - mmr_pkg::MAX_BASE;
	assign inRt = (readRegister >= mmr_pkg::RT_BASE) && (32'(rtOff) < PARAMS);
	assign inMin = (readRegister >= mmr_pkg::MIN_BASE) && (32'(minOff) < PARAMS);
	assign inMax = (readRegister >= mmr_pkg::MAX_BASE) && (32'(maxOff) < PARAMS);
	assign rtIdx = inRt ? rtOff[mmr_pkg::INDEX_WIDTH-1:0] : '0;
	assign minIdx = inMin ? minOff[mmr_pkg::INDEX_WIDTH-1:0] : '0;
	assign maxIdx = inMax ? maxOff[mmr_pkg::INDEX_WIDTH-1:0] : '0;
	// A slot that was never refreshed, was cleared, or has no extreme at all
	// reads as the not-available code rather than a stale or made-up number.
	assign rtBlank = !rtValid_q[rtIdx];
	assign minBlank = NO_MIN_MASK[minIdx] || !extValid_q[minIdx];
	assign maxBlank = NO_MAX_MASK[maxIdx] || !extValid_q[maxIdx];
	assign rtWord = rtBlank ? mmr_pkg::NOT_AVAILABLE : rtMem[rtIdx];
	assign minWord = minBlank ? mmr_pkg::NOT_AVAILABLE : minMem[minIdx];
	assign maxWord = maxBlank ? mmr_pkg::NOT_AVAILABLE : maxMem[maxIdx];
	// The windows are disjoint, so the order of this selection carries no priority.
	assign readMapped = inRt || inMin || inMax;
	assign readTake = clockEnable && readValid;
	assign readMux = inRt ? rtWord : (inMin ? minWord : (inMax ? maxWord : mmr_pkg::RESET_DATA));

	// The answer pulses last one enabled cycle; the data word holds until the
	// next read so that a slow master can still pick it up.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			readDone_q <= 1'b0;
		end else if (clockEnable) begin
			readDone_q <= readValid;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			readError_q <= 1'b0;
		end else if (clockEnable) begin
			readError_q <= readValid && !readMapped;
		end
	end

	// Unmapped numbers answer with zero data next to the error flag.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			readData_q <= mmr_pkg::RESET_DATA;
		end else if (readTake) begin
			readData_q <= readMux;
		end
	end

	assign readData = readData_q;
	assign readDone = readDone_q;
	assign readError = readError_q;
endmodule // mmr_minmax_bank

// *** logic/mmr_pkg.sv ***
// Package of register numbers, codes and widths for the min/max measurement bank.
// Behaviour
// - Extremes compare samples by absolute magnitude, so larger negative beats smaller positive.
// - Power factor entries compare signed; minimum is the most negative value seen.
// - Command code 46728 clears every tracked minimum and maximum register.
// - Minimum of real-time register N is readable at register N plus 300.
// - Maximum of real-time register N is readable at register N plus 600.
// - Extremes keep the same scale and encoding as the real-time register.
// - Unbalance current and voltage minimum slots carry no valid measurement.
// - No minimum for registers 1026, 1145 and 1146.
// - No maximum for registers 1026, 1145 and 1146.
// - Registers 1099 and 1100 give phase 2 and 3 current distortion, scale 10.
// - Register 1144 gives motor thermal image percentage, scale 1, read only.
package mmr_pkg;
	localparam int DATA_WIDTH = 16;
	localparam int ADDR_WIDTH = 16;
	localparam int PARAM_COUNT = 300;
	localparam int INDEX_WIDTH = 9;
	localparam logic [15:0] RT_BASE = 16'h03E8;
	localparam logic [15:0] MIN_BASE = 16'h0514;
	localparam logic [15:0] MAX_BASE = 16'h0640;
	localparam logic [15:0] MIN_OFFSET = 16'h012C;
	localparam logic [15:0] MAX_OFFSET = 16'h0258;
	localparam logic [15:0] PHASE2_CURRENT_DISTORTION = 16'h044B;
	localparam logic [15:0] PHASE3_CURRENT_DISTORTION = 16'h044C;
	localparam logic [15:0] MOTOR_THERMAL_IMAGE = 16'h0478;
	localparam logic [15:0] MOTOR_THERMAL_IMAGE_ADDR = 16'h0477;
	localparam logic [15:0] LOWEST_PHASE_CURRENT = 16'h0402;
	localparam logic [15:0] HIGHEST_VOLTAGE = 16'h0479;
	localparam logic [15:0] LOWEST_VOLTAGE = 16'h047A;
	localparam logic [15:0] CLEAR_EXTREMES_CODE = 16'hB688;
	localparam logic [15:0] NOT_AVAILABLE = 16'h8000;
	localparam logic [15:0] RESET_DATA = 16'h0000;
	localparam logic [PARAM_COUNT-1:0] NO_EXTREME_MASK =
		(300'h1 << (LOWEST_PHASE_CURRENT - RT_BASE)) |
		(300'h1 << (HIGHEST_VOLTAGE - RT_BASE)) |
		(300'h1 << (LOWEST_VOLTAGE - RT_BASE));
endpackage // mmr_pkg

// *** logic/mmr_extreme_compare.sv ***
// Comparator that decides whether a sample is a new minimum or maximum.
module mmr_extreme_compare #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] sample,
	input wire logic [WIDTH-1:0] stored,
	input wire logic signedMode,
	output logic newMin,
	output logic newMax
);
	wire logic [WIDTH:0] sampleMag;
	wire logic [WIDTH:0] storedMag;
	wire logic signedLess;
	wire logic signedMore;
	wire logic magLess;
	wire logic magMore;

	// Magnitudes are one bit wider so the most negative code has a true absolute value.
	assign sampleMag = sample[WIDTH-1] ? ({1'b0, ~sample} + 1'b1) : {1'b0, sample};
	assign storedMag = stored[WIDTH-1] ? ({1'b0, ~stored} + 1'b1) : {1'b0, stored};
	assign magLess = sampleMag < storedMag;
	assign magMore = sampleMag > storedMag;
	assign signedLess = $signed(sample) < $signed(stored);
	assign signedMore = $signed(sample) > $signed(stored);
	assign newMin = signedMode ? signedLess : magLess;
	assign newMax = signedMode ? signedMore : magMore;
endmodule // mmr_extreme_compare

// *** test/mmr_minmax_asserts.sv ***
// Checker of read answers, register map and clearing of the min/max bank.
module mmr_minmax_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic updateValid,
	input wire logic commandValid,
	input wire logic [15:0] commandCode,
	input wire logic readValid,
	input wire logic [15:0] readRegister,
	input wire logic [15:0] readData,
	input wire logic readDone,
	input wire logic readError
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic take = clockEnable && readValid;
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);
	sequence clearThenRead;
		clockEnable && commandValid && commandCode == 16'hB688 && !updateValid ##1 !updateValid
			##1 take && !updateValid && readRegister inside {[16'h0514:16'h076B]};
	endsequence
	chk_read_answer: assert property (take |=> readDone)
		else $error("no answer");
	chk_done_only: assert property (clockEnable && !readValid |=> !readDone)
		else $error("stray done");
	chk_error_zero: assert property (readError |-> readDone && readData == 16'h0000)
		else $error("bad error word");
	chk_bank_mapped: assert property (take && readRegister inside {[16'h03E8:16'h076B]} |=> !readError)
		else $error("mapped refused");
	chk_past_end: assert property (take && readRegister > 16'h076B |=> readError)
		else $error("unmapped taken");
	chk_clear_empty: assert property (clearThenRead |=> readData == 16'h8000)
		else $error("extreme kept");
	chk_no_min: assert property (take && readRegister inside {16'h052E, 16'h05A5, 16'h05A6} |=> readData == 16'h8000)
		else $error("minimum given");
	chk_no_max: assert property (take && readRegister inside {16'h065A, 16'h06D1, 16'h06D2} |=> readData == 16'h8000)
		else $error("maximum given");
endmodule // mmr_minmax_asserts

bind mmr_minmax_bank mmr_minmax_asserts u_chk (.clock(clock), .reset(reset),
	.clockEnable(clockEnable), .updateValid(updateValid), .commandValid(commandValid),
	.commandCode(commandCode), .readValid(readValid), .readRegister(readRegister),
	.readData(readData), .readDone(readDone), .readError(readError));

// *** test/mmr_master_model.sv ***
// Model of the remote master that polls registers and sends commands.
module mmr_master_model (
	input wire logic clock,
	output logic readValid,
	output logic [15:0] readRegister,
	input wire logic [15:0] readData,
	input wire logic readDone,
	input wire logic readError,
	output logic commandValid,
	output logic [15:0] commandCode
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		readValid = 1'b0;
		readRegister = 16'h0000;
		commandValid = 1'b0;
		commandCode = 16'h0000;
	end
	// Released lines show the inverse so a stale value is never mistaken for a live one.
	task automatic read_reg(input logic [15:0] r, output logic [15:0] d, output logic e);
		@(posedge clock);
		readValid <= 1'b1;
		readRegister <= r;
		@(posedge clock);
		readValid <= 1'b0;
		readRegister <= ~r;
		// The answer stands for the whole next cycle and is taken at its closing edge.
		@(posedge clock);
		d = readDone ? readData : 16'hXXXX;
		e = readError;
	endtask
	task automatic send_cmd(input logic [15:0] c);
		@(posedge clock);
		commandValid <= 1'b1;
		commandCode <= c;
		@(posedge clock);
		commandValid <= 1'b0;
		commandCode <= ~c;
	endtask
endmodule // mmr_master_model

// *** test/testbench.sv ***
// Testbench that feeds samples and checks extremes through the master model.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic updateValid = 1'b0;
	logic [8:0] updateIndex = 9'h000;
	logic [15:0] updateValue = 16'h0000;
	logic clockEnable = 1'b1;
	logic [15:0] frozenData;
	logic frozenError;
	logic readValid, readDone, readError, commandValid;
	logic [15:0] readRegister, readData, commandCode;
	logic [8:0] noIdx [3] = '{9'h01A, 9'h091, 9'h092};
	logic [15:0] noSlot [6] = '{16'h052E, 16'h05A5, 16'h05A6, 16'h065A, 16'h06D1, 16'h06D2};
	int num_errors = 0;
	int cmp_count = 0;
	always #5 clock = ~clock;
	// Index 40 plays a power factor and index 50 an unbalance value; both picks are arbitrary.
	mmr_minmax_bank #(.SIGNED_MASK(300'h1 << 40),
		.NO_MIN_MASK(mmr_pkg::NO_EXTREME_MASK | (300'h1 << 50))) uut (.clock(clock),
		.reset(reset), .clockEnable(clockEnable), .updateValid(updateValid), .updateIndex(updateIndex),
		.updateValue(updateValue), .commandValid(commandValid), .commandCode(commandCode),
		.readValid(readValid), .readRegister(readRegister), .readData(readData),
		.readDone(readDone), .readError(readError));
	mmr_master_model u_master (.clock(clock), .readValid(readValid),
		.readRegister(readRegister), .readData(readData), .readDone(readDone),
		.readError(readError), .commandValid(commandValid), .commandCode(commandCode));
	task automatic finish_test;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h got %h", n, exp, got);
		end
	endtask
	task automatic upd(input logic [8:0] i, input logic [15:0] v);
		@(posedge clock);
		updateValid <= 1'b1;
		updateIndex <= i;
		updateValue <= v;
		@(posedge clock);
		updateValid <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] r, input logic [15:0] exp);
		logic [15:0] d;
		logic e;
		u_master.read_reg(r, d, e);
		chk($sformatf("reg %h data", r), exp, d);
		chk($sformatf("reg %h error", r), {15'h0000, r < 16'h03E8 || r > 16'h076B}, {15'h0000, e});
	endtask
	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		rd(16'h0640, 16'h8000);
		upd(9'h000, 16'hFC18);
		rd(16'h0514, 16'hFC18);
		rd(16'h0640, 16'hFC18);
		upd(9'h000, 16'h000A);
		upd(9'h000, 16'h0258);
		rd(16'h0514, 16'h000A);
		rd(16'h0640, 16'hFC18);
		rd(16'h03E8, 16'h0258);
		upd(9'h028, 16'h0005);
		upd(9'h028, 16'hFFF0);
		rd(16'h053C, 16'hFFF0);
		rd(16'h0668, 16'h0005);
		upd(9'h032, 16'h0007);
		rd(16'h0546, 16'h8000);
		rd(16'h0672, 16'h0007);
		foreach (noIdx[k]) upd(noIdx[k], 16'h0100);
		foreach (noSlot[k]) rd(noSlot[k], 16'h8000);
		upd(9'h063, 16'h7FFE);
		upd(9'h064, 16'h0000);
		upd(9'h090, 16'h0064);
		rd(16'h044B, 16'h7FFE);
		rd(16'h044C, 16'h0000);
		rd(16'h0478, 16'h0064);
		u_master.send_cmd(16'hB689);
		rd(16'h0640, 16'hFC18);
		u_master.send_cmd(16'hB688);
		rd(16'h0514, 16'h8000);
		rd(16'h0640, 16'h8000);
		rd(16'h03E8, 16'h0258);
		upd(9'h000, 16'h0003);
		rd(16'h0640, 16'h0003);
		clockEnable <= 1'b0;
		upd(9'h000, 16'h7000);
		u_master.read_reg(16'h0640, frozenData, frozenError);
		chk("frozen readDone", 16'h0000, {15'h0000, readDone});
		clockEnable <= 1'b1;
		rd(16'h0640, 16'h0003);
		rd(16'h03E8, 16'h0003);
		fork
			u_master.send_cmd(16'hB688);
			upd(9'h000, 16'h0009);
		join
		rd(16'h0514, 16'h0009);
		rd(16'h0640, 16'h0009);
		rd(16'h076C, 16'h0000);
		rd(16'h03E7, 16'h0000);
		finish_test;
	end
	// The sequence needs about 130 cycles, so this margin only trips on a hang.
	initial begin
		repeat (2000) @(posedge clock);
		num_errors++;
		finish_test;
	end
endmodule // testbench
